// [ajd_defs.svh]
// register offsets, reset values and field positions for the jack detect register bank
`ifndef AJD_DEFS_SVH
`define AJD_DEFS_SVH
`define AJD_OFS_STATUS      8'h11
`define AJD_OFS_ENABLE      8'h12
`define AJD_OFS_FLAGS       8'h18
`define AJD_OFS_MASKS       8'h19
`define AJD_OFS_VOLT_FIRST  8'h1A
`define AJD_OFS_VOLT_SECOND 8'h1B
`define AJD_OFS_MIC_FIRST   8'h1C
`define AJD_OFS_MIC_SECOND  8'h1D
`define AJD_OFS_SOFT_RESET  8'h1E
`define AJD_OFS_CURRENT     8'h1F
`define AJD_RST_FLAGS       3'h0
`define AJD_RST_MASKS       3'h0
`define AJD_RST_VOLT_FIRST  8'h7F
`define AJD_RST_VOLT_SECOND 8'hFF
`define AJD_RST_MIC_FIRST   8'h20
`define AJD_RST_MIC_SECOND  8'hFF
`define AJD_RST_CURRENT     4'h0
`define AJD_RST_ENABLE      2'h0
`define AJD_CURRENT_INVALID 4'h0
`define AJD_CURRENT_DEFAULT 4'h7
`define AJD_BIT_JACK_DONE   2
`define AJD_BIT_LOW_RES     1
`define AJD_BIT_RES_DONE    0
`endif

// [ajd_engine_model.sv]
// detection engine stand-in that answers the detection enables
`timescale 1ns/10ps
`default_nettype none
module ajd_engine_model (
    input  wire logic              clock_in,   // bank clock
    input  wire logic              jack_en_in, // jack run requested
    input  wire logic              res_en_in,  // resistance run requested
    input  wire logic              low_in,     // report a low resistance
    input  wire logic [7:0]        code_in,    // voltage code to report
    output var  ajd_pkg::ajd_evt_t evt_out     // one-cycle event pulses
);
    // ==========================================================
    // run counters: three cycles per run, saturate so a run answers once
    logic [2:0] jack_cnt = 3'h0;
    logic [2:0] res_cnt  = 3'h0;
    always_ff @(posedge clock_in) begin
        jack_cnt <= (jack_en_in === 1'h1) ? jack_cnt + 3'(jack_cnt != 3'h7) : 3'h0;
        res_cnt  <= (res_en_in === 1'h1) ? res_cnt + 3'(res_cnt != 3'h7) : 3'h0;
    end
    // readings travel with the jack result, second side is the inverse code
    assign evt_out = '{jack_cnt == 3'h3, low_in && res_cnt == 3'h3, res_cnt == 3'h3,
                       jack_cnt == 3'h3, code_in, ~code_in};
endmodule : ajd_engine_model
`default_nettype wire

// [ajd_pkg.sv]
// types shared by the jack detect register bank
`default_nettype none
package ajd_pkg;
    // =====================================================================
    // register access request from the serial target
    typedef struct packed {
        logic       wr;      // write strobe, one cycle
        logic       rd;      // read strobe, one cycle
        logic [7:0] addr;    // register offset
        logic [7:0] wdata;   // write data
    } ajd_req_t;
    // events from the detection engines, one-cycle pulses
    typedef struct packed {
        logic       jack_done;   // jack detection and configuration finished
        logic       low_res;     // low resistance seen
        logic       res_done;    // resistance detection run finished
        logic       volt_valid;  // new voltage readings present
        logic [7:0] volt_first;  // first side voltage code
        logic [7:0] volt_second; // second side voltage code
    } ajd_evt_t;
endpackage : ajd_pkg
`default_nettype wire

// [ajd_regs.sv]
// register bank for audio jack detection flags, masks, readings and settings
`timescale 1ns/10ps
`default_nettype none
`include "ajd_defs.svh"
module ajd_regs (
    input  wire logic            clock_in,        // 40 MHz clock
    input  wire logic            rst_b_in,        // asynchronous reset, active low
    input  wire logic            clk_en_in,       // freezes all state while low
    input  wire ajd_pkg::ajd_req_t req_in,        // register access request
    input  wire ajd_pkg::ajd_evt_t evt_in,        // detection engine events
    input  wire logic            accessory_in,    // high while an accessory is attached
    output logic [7:0]           rdata_out,       // read data, registered
    output logic                 int_b_out,       // interrupt, active low, registered
    output logic                 if_reset_out,    // serial interface reset pulse
    output logic                 res_det_en_out,  // resistance detection enable
    output logic                 jack_det_en_out, // jack detection enable
    output logic [3:0]           current_out,     // detection source current code
    output logic [7:0]           mic_first_out,   // first mic threshold word
    output logic [7:0]           mic_second_out   // second mic threshold word
);
    // =====================================================================
    // state
    logic [2:0] flags_reg,  flags_next;   // sticky event flags
    logic [2:0] masks_reg,  masks_next;   // interrupt masks
    logic [7:0] vfirst_reg, vfirst_next;  // first side voltage
    logic [7:0] vsec_reg,   vsec_next;    // second side voltage
    logic [7:0] micf_reg,   micf_next;    // mic_threshold_first_word
    logic [7:0] mics_reg,   mics_next;    // mic_threshold_second_word
    logic       srst_reg,   srst_next;    // interface reset, self clearing
    logic [3:0] cur_reg,    cur_next;     // current source setting
    logic [1:0] en_reg,     en_next;      // detection enables, bit1 res, bit0 jack
    logic [7:0] rdata_reg,  rdata_next;   // read data holding
    logic       intb_reg,   intb_next;    // interrupt pin level
    logic [2:0] evt_vec;                  // events in flag order
    logic       rd_flags;                 // read of the flag register this cycle
    wire  [2:0] flag_upd;                 // per-bit flag value for next cycle
    wire  [2:0] flag_live;                // per-bit flag that may pull the pin

    // =====================================================================
    // access decode
    // events are gathered in flag order so the per-bit loop can index them
    assign evt_vec  = {evt_in.jack_done, evt_in.low_res, evt_in.res_done};
    // the read clear is decoded once for the flag loop; the read mux decodes the offset in its own case
    assign rd_flags = req_in.rd && (req_in.addr == `AJD_OFS_FLAGS);

    // =====================================================================
    // per-flag update, one copy for each event bit
    for (genvar i = 0; i < 3; i++) begin : g_flag
        // a same-cycle event beats the read clear, so no event is lost to a read
        assign flag_upd[i]  = (flags_reg[i] && !rd_flags) || evt_vec[i];
        // a masked flag still records its event but stays off the pin
        assign flag_live[i] = flag_upd[i] && !masks_next[i];
    end

    // =====================================================================
    // read data: next value
    // the mux only moves on a read strobe, so the last answer stands until
    // the host asks again; reserved bits and unmapped offsets read as zero
    always_comb begin
        rdata_next = rdata_reg;                          // hold between reads
        if (req_in.rd) begin
            // a read sees the flags as they stood before this edge
            unique case (req_in.addr)
                `AJD_OFS_STATUS:      rdata_next = {7'h00, ~accessory_in};
                `AJD_OFS_ENABLE:      rdata_next = {6'h00, en_reg};
                `AJD_OFS_FLAGS:       rdata_next = {5'h00, flags_reg};
                `AJD_OFS_MASKS:       rdata_next = {5'h00, masks_reg};
                `AJD_OFS_VOLT_FIRST:  rdata_next = vfirst_reg;
                `AJD_OFS_VOLT_SECOND: rdata_next = vsec_reg;
                `AJD_OFS_MIC_FIRST:   rdata_next = micf_reg;
                `AJD_OFS_MIC_SECOND:  rdata_next = mics_reg;
                `AJD_OFS_CURRENT:     rdata_next = {4'h0, cur_reg};
                default:              rdata_next = 8'h00;                // unmapped and write-only
            endcase
        end
    end

    // =====================================================================
    // flags and interrupt pin: next value
    // the pin is worked out from the flags as they will stand next cycle,
    // so the pin never trails the flag register by a cycle
    always_comb begin
        flags_next = flag_upd;
        intb_next  = ~|flag_live;
    end

    // =====================================================================
    // host settings: next value
    always_comb begin
        masks_next = masks_reg;                          // masks hold unless written
        micf_next  = micf_reg;                           // mic_threshold_first_word
        mics_next  = mics_reg;                           // mic_threshold_second_word
        srst_next  = 1'b0;
        cur_next   = cur_reg;                            // current code holds
        en_next    = en_reg;                             // enables hold
        if (req_in.wr) begin
            unique case (req_in.addr)
                `AJD_OFS_ENABLE:     en_next    = req_in.wdata[1:0];
                `AJD_OFS_MASKS:      masks_next = req_in.wdata[2:0];
                `AJD_OFS_MIC_FIRST:  micf_next  = req_in.wdata;
                `AJD_OFS_MIC_SECOND: mics_next  = req_in.wdata;
                `AJD_OFS_SOFT_RESET: srst_next  = req_in.wdata[0];
                `AJD_OFS_CURRENT: begin
                    // a forbidden zero code is refused, setting is kept
                    if (req_in.wdata[3:0] != `AJD_CURRENT_INVALID) begin
                        cur_next = req_in.wdata[3:0];
                    end
                end
                default: ;                               // read-only or unmapped
            endcase
        end
        // a finished run drops its enable even against a same-cycle write,
        // so a stale write cannot restart a run that has just ended
        if (evt_in.res_done) begin
            en_next[1] = 1'b0;
        end
        if (evt_in.jack_done) begin
            en_next[0] = 1'b0;
        end
    end

    // =====================================================================
    // detection readings: next value
    // readings move only when the engine marks them new; the host cannot
    // write them, so a write to either offset is simply ignored
    always_comb begin
        vfirst_next = vfirst_reg;
        vsec_next   = vsec_reg;
        if (evt_in.volt_valid) begin
            vfirst_next = evt_in.volt_first;
            vsec_next   = evt_in.volt_second;
        end
    end

    // =====================================================================
    // read data register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_reg <= 8'h00;                          // bus reads zero after reset
        end else if (clk_en_in) begin
            rdata_reg <= rdata_next;
        end
    end

    // =====================================================================
    // flag and pin registers
    // events that arrive while the clock enable is low are not recorded;
    // the engines are expected to run on the same enable
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            flags_reg <= `AJD_RST_FLAGS;
            intb_reg  <= 1'b1;                           // pin released in reset
        end else if (clk_en_in) begin
            flags_reg <= flags_next;
            intb_reg  <= intb_next;
        end
    end

    // =====================================================================
    // host setting registers
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            masks_reg <= `AJD_RST_MASKS;
            micf_reg  <= `AJD_RST_MIC_FIRST;
            mics_reg  <= `AJD_RST_MIC_SECOND;
            srst_reg  <= 1'b0;                           // no pulse in reset
            cur_reg   <= `AJD_RST_CURRENT;               // zero code until written
            en_reg    <= `AJD_RST_ENABLE;                // no run in reset
        end else if (clk_en_in) begin
            masks_reg <= masks_next;
            micf_reg  <= micf_next;
            mics_reg  <= mics_next;
            srst_reg  <= srst_next;
            cur_reg   <= cur_next;
            en_reg    <= en_next;
        end
    end

    // =====================================================================
    // detection reading registers
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vfirst_reg <= `AJD_RST_VOLT_FIRST;
            vsec_reg   <= `AJD_RST_VOLT_SECOND;
        end else if (clk_en_in) begin
            vfirst_reg <= vfirst_next;
            vsec_reg   <= vsec_next;
        end
    end

    // =====================================================================
    // outputs
    // every output comes straight from a flip-flop, so nothing downstream
    // sees a glitch from the request decode
    assign rdata_out       = rdata_reg;
    assign int_b_out       = intb_reg;
    assign if_reset_out    = srst_reg;
    assign res_det_en_out  = en_reg[1];
    assign jack_det_en_out = en_reg[0];
    assign current_out     = cur_reg;
    assign mic_first_out   = micf_reg;
    assign mic_second_out  = mics_reg;
endmodule : ajd_regs
`default_nettype wire

// [ajd_regs_sva.sv]
// port-level assertion checker for the jack detect register bank
`timescale 1ns/10ps
`default_nettype none
module ajd_regs_sva (
    input wire logic              clock_in,
    input wire logic              rst_b_in,
    input wire logic              clk_en_in,
    input wire ajd_pkg::ajd_req_t req_in,
    input wire ajd_pkg::ajd_evt_t evt_in,
    input wire logic              accessory_in,
    input wire logic [7:0]        rdata_out,
    input wire logic              int_b_out,
    input wire logic              if_reset_out,
    input wire logic              res_det_en_out,
    input wire logic              jack_det_en_out,
    input wire logic [3:0]        current_out,
    input wire logic [7:0]        mic_first_out,
    input wire logic [7:0]        mic_second_out
);
    // ==========================================================
    // helpers: accesses taken at this edge, and no event racing a read
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    wire       rd = clk_en_in && req_in.rd;
    wire       wr = clk_en_in && req_in.wr;
    wire [7:0] a  = req_in.addr;
    wire       ne = !(evt_in.jack_done || evt_in.low_res || evt_in.res_done);
    acc_stat_a: assert property (rd&&a==8'h11 |=> rdata_out=={7'h00,!$past(accessory_in)})
        else $error("status read wrong");
    flag_clear_a: assert property (rd&&a==8'h18&&ne ##1 rd&&a==8'h18 |=> rdata_out==8'h00)
        else $error("flags not cleared by read");
    rsv_bits_a: assert property (rd&&(a==8'h18||a==8'h19) |=> rdata_out[7:3]==5'h00)
        else $error("reserved bits set");
    jack_flag_a: assert property (clk_en_in&&evt_in.jack_done ##1 rd&&a==8'h18 |=> rdata_out[2])
        else $error("jack flag missing");
    jack_en_a: assert property (clk_en_in&&evt_in.jack_done&&!(wr&&a==8'h12) |=> !jack_det_en_out)
        else $error("jack enable stuck");
    res_en_a: assert property (clk_en_in&&evt_in.res_done&&!(wr&&a==8'h12) |=> !res_det_en_out)
        else $error("res enable stuck");
    int_release_a: assert property (rd&&a==8'h18&&ne |=> int_b_out)
        else $error("interrupt not released");
    if_pulse_a: assert property (wr&&a==8'h1E&&req_in.wdata[0] |=> if_reset_out ##1 !if_reset_out)
        else $error("interface reset pulse wrong");
    cur_keep_a: assert property (wr&&a==8'h1F&&req_in.wdata[3:0]==4'h0 |=> $stable(current_out))
        else $error("zero current accepted");
    mic_one_a: assert property (wr&&a==8'h1C |=> mic_first_out==$past(req_in.wdata))
        else $error("first threshold wrong");
    mic_two_a: assert property (wr&&a==8'h1D |=> mic_second_out==$past(req_in.wdata))
        else $error("second threshold wrong");
endmodule : ajd_regs_sva
bind ajd_regs ajd_regs_sva i_ajd_regs_sva (.*);
`default_nettype wire

// [ajd_regs_tb.sv]
// self-checking testbench for the jack detect register bank
`timescale 1ns/10ps
`default_nettype none
module ajd_regs_tb;
    // ==========================================================
    logic clock_in = 1'h0;
    logic rst_b_in = 1'h0;
    logic clk_en = 1'h1;
    logic acc_in = 1'h0;
    logic low_in = 1'h0;
    logic pend = 1'h0;
    logic [31:0] rnd = 32'h9742;
    ajd_pkg::ajd_req_t req = '0;
    ajd_pkg::ajd_evt_t evt;
    logic [7:0] rdata, mic1, mic2, q[$];
    logic int_b, ifr, res_en, jack_en;
    logic [3:0] cur;
    logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h7F, 8'hFF, 8'h20, 8'hFF, 8'h00, 8'h00};
    int err_total = 0;
    int total_checks = 0;
    int n;
    always #12.5 clock_in = ~clock_in;
    ajd_regs i_ajd_regs (.clock_in(clock_in), .rst_b_in(rst_b_in), .clk_en_in(clk_en),
        .req_in(req), .evt_in(evt), .accessory_in(acc_in), .rdata_out(rdata),
        .int_b_out(int_b), .if_reset_out(ifr), .res_det_en_out(res_en),
        .jack_det_en_out(jack_en), .current_out(cur), .mic_first_out(mic1),
        .mic_second_out(mic2));
    ajd_engine_model i_ajd_engine_model (.clock_in(clock_in), .jack_en_in(jack_en),
        .res_en_in(res_en), .low_in(low_in), .code_in(rnd[7:0]), .evt_out(evt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one access per cycle; d is write data, or the expected read data
    task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        req = '{w, !w, ad, d};
        if (!w) q.push_back(d);
    endtask : acc
    task automatic idle();
        @(posedge clock_in);
        #1;
        req = '0;
    endtask : idle
    // bounded wait for both detection enables to drop
    task automatic wait_done();
        for (n = 0; n < 40 && (jack_en | res_en) !== 1'h0; n++) @(posedge clock_in);
        if (n == 40) begin
            err_total++;
            final_report();
        end
        #1;
    endtask : wait_done
    task automatic final_report();
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    // read data lands one edge after the read is taken
    always @(negedge clock_in) begin
        if (pend) chk(rdata, q.pop_front());
        pend = req.rd && clk_en && rst_b_in;
    end
    initial begin
        repeat (20) @(posedge clock_in);
        #1;
        rst_b_in = 1'h1;
        acc(1'h0, 8'h11, 8'h01);
        for (n = 0; n < 8; n++) acc(1'h0, 8'h18 + 8'(n), rst_tab[n]);
        rnd = lfsr(rnd);
        acc(1'h1, 8'h1C, rnd[7:0]);
        acc(1'h1, 8'h1D, rnd[15:8]);
        acc(1'h1, 8'h1F, 8'h05);
        acc(1'h1, 8'h1F, 8'h00);
        acc(1'h1, 8'h19, 8'hFF);
        acc(1'h1, 8'h1A, 8'h00);
        acc(1'h0, 8'h1C, rnd[7:0]);
        acc(1'h0, 8'h1D, rnd[15:8]);
        acc(1'h0, 8'h1F, 8'h05);
        acc(1'h0, 8'h19, 8'h07);
        acc(1'h0, 8'h1A, 8'h7F);
        chk({4'h0, cur}, 8'h05);
        chk(mic1, rnd[7:0]);
        chk(mic2, rnd[15:8]);
        acc(1'h1, 8'h12, 8'h01);
        idle();
        wait_done();
        chk({7'h00, int_b}, 8'h01);
        acc(1'h0, 8'h18, 8'h04);
        acc(1'h0, 8'h1A, rnd[7:0]);
        acc(1'h0, 8'h1B, ~rnd[7:0]);
        acc(1'h1, 8'h19, 8'h00);
        low_in = 1'h1;
        acc(1'h1, 8'h12, 8'h02);
        idle();
        wait_done();
        chk({7'h00, int_b}, 8'h00);
        acc(1'h0, 8'h18, 8'h03);
        acc(1'h0, 8'h18, 8'h00);
        acc(1'h1, 8'h1E, 8'h01);
        idle();
        chk({6'h00, int_b, ifr}, 8'h03);
        idle();
        chk({7'h00, ifr}, 8'h00);
        clk_en = 1'h0;
        acc(1'h1, 8'h1C, ~rnd[7:0]);
        idle();
        clk_en = 1'h1;
        acc_in = 1'h1;
        acc(1'h0, 8'h1C, rnd[7:0]);
        acc(1'h0, 8'h11, 8'h00);
        idle();
        idle();
        rst_b_in = 1'h0;
        repeat (3) @(posedge clock_in);
        #1;
        rst_b_in = 1'h1;
        acc(1'h0, 8'h1C, 8'h20);
        acc(1'h0, 8'h1F, 8'h00);
        idle();
        repeat (2) @(posedge clock_in);
        final_report();
    end
    initial begin
        #200000;
        err_total++;
        final_report();
    end
endmodule : ajd_regs_tb
`default_nettype wire
